// ### rtl/sil_blink.sv
// Purpose: Shared blink square wave at the selected rate
// Assumes: One clock; rate may change at any time
// Notes:   A rate change takes effect in the current half period; a count already past the new limit toggles at once
`timescale 1ns/100ps
module sil_blink #(
	parameter int unsigned C20 = sil_pkg::BLINK_CYC_20HZ,
	parameter int unsigned C10 = sil_pkg::BLINK_CYC_10HZ,
	parameter int unsigned C5  = sil_pkg::BLINK_CYC_5HZ,
	parameter int unsigned C2  = sil_pkg::BLINK_CYC_2HZ
) (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [1:0] rate_i,
	output logic            blink_o
);
	typedef struct packed {
		logic [24:0] cnt;
		logic        ph;
	} sil_bst_t;

	sil_bst_t st_r;
	sil_bst_t st_nxt;
	logic [24:0] lim;

	always_comb
	begin
		case (rate_i)
			2'b00:   lim = 25'(C20 - 1);
			2'b01:   lim = 25'(C10 - 1);
			2'b10:   lim = 25'(C5 - 1);
			default: lim = 25'(C2 - 1);
		endcase
		st_nxt = st_r;
		if (st_r.cnt >= lim)
		begin
			st_nxt.cnt = '0;
			st_nxt.ph  = ~st_r.ph;
		end
		else
			st_nxt.cnt = st_r.cnt + 25'h000_0001;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign blink_o = st_r.ph;
endmodule

// ### rtl/sil_pkg.sv
// Purpose: Shared constants and carriers for the status indicator block
// Assumes: 40 MHz system clock, 32-bit classic Wishbone register access
// Notes:   Register index 0x450 sits at byte address 4*0x450
package sil_pkg;

	localparam int unsigned CLK_HZ          = 40_000_000;
	// Register indices; byte address is four times the index
	localparam logic [11:0] IDX_IND_CFG     = 12'h0450;
	localparam logic [11:0] IDX_MUX_CFG     = 12'h0452;
	localparam logic [11:0] IDX_IND_STAT    = 12'h0460;
	localparam logic [13:0] ADR_IND_CFG     = {IDX_IND_CFG, 2'b00};
	localparam logic [13:0] ADR_MUX_CFG     = {IDX_MUX_CFG, 2'b00};
	localparam logic [13:0] ADR_IND_STAT    = {IDX_IND_STAT, 2'b00};
	localparam logic [15:0] IND_CFG_RST     = 16'h2610;
	localparam logic [15:0] MUX_CFG_RST     = 16'h0000;
	localparam logic [15:0] IND_CFG_WMASK   = 16'h7FFF;
	localparam logic [15:0] MUX_CFG_WMASK   = 16'h0707;
	// Field positions inside the indicator and pin mux configurations
	localparam int unsigned SEL0_LSB        = 0;
	localparam int unsigned SEL1_LSB        = 4;
	localparam int unsigned SEL2_LSB        = 8;
	localparam int unsigned RATE_LSB        = 12;
	localparam int unsigned BYPASS_BIT      = 14;
	localparam int unsigned MUX1_LSB        = 8;

	// Blink half periods and stretch time in ms, and derived cycle counts
	localparam int unsigned BLINK_MS_20HZ   = 50;
	localparam int unsigned BLINK_MS_10HZ   = 100;
	localparam int unsigned BLINK_MS_5HZ    = 200;
	localparam int unsigned BLINK_MS_2HZ    = 500;
	localparam int unsigned STRETCH_MS      = 50;
	localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
	localparam int unsigned BLINK_CYC_20HZ  = BLINK_MS_20HZ * CYC_PER_MS;
	localparam int unsigned BLINK_CYC_10HZ  = BLINK_MS_10HZ * CYC_PER_MS;
	localparam int unsigned BLINK_CYC_5HZ   = BLINK_MS_5HZ * CYC_PER_MS;
	localparam int unsigned BLINK_CYC_2HZ   = BLINK_MS_2HZ * CYC_PER_MS;
	localparam int unsigned STRETCH_CYC     = STRETCH_MS * CYC_PER_MS;

	// Indicator function codes
	localparam logic [3:0] FN_LINK          = 4'h0;
	localparam logic [3:0] FN_LINK_ACT      = 4'h1;
	localparam logic [3:0] FN_LINK_TX       = 4'h2;
	localparam logic [3:0] FN_LINK_RX       = 4'h3;
	localparam logic [3:0] FN_MASTER        = 4'h4;
	localparam logic [3:0] FN_SLAVE         = 4'h5;
	localparam logic [3:0] FN_ACT           = 4'h6;
	localparam logic [3:0] FN_LOST          = 4'h9;
	localparam logic [3:0] FN_PRBS          = 4'hA;
	localparam logic [3:0] FN_MAC_ERR       = 4'hB;

	// Pin mux codes
	localparam logic [2:0] MUX_INDICATOR    = 3'h0;
	localparam logic [2:0] MUX_CONST0       = 3'h6;
	localparam logic [2:0] MUX_CONST1       = 3'h7;

	typedef struct packed {
		logic link_good;
		logic is_master;
		logic tx_act;
		logic rx_act;
		logic mac_err;
		logic link_lost_latch;
		logic prbs_latch;
		logic blink;
	} sil_evt_t;

	typedef struct packed {
		logic [31:0] adr;
		logic [31:0] dat;
		logic [3:0]  sel;
		logic        we;
		logic        cyc;
		logic        stb;
	} sil_wb_req_t;

endpackage

// ### rtl/sil_stretch.sv
// Purpose: Lengthens short event pulses so a lamp shows them
// Assumes: Event is a level or pulse in the clock domain
// Notes:   Bypass passes the event straight through
`timescale 1ns/100ps
module sil_stretch #(
	parameter int unsigned HOLD = sil_pkg::STRETCH_CYC
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic evt_i,
	input  wire logic bypass_i,
	output logic      out_o
);
	typedef struct packed {
		logic [23:0] cnt;
	} sil_sst_t;

	sil_sst_t st_r;
	sil_sst_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		if (evt_i)
			st_nxt.cnt = 24'(HOLD);
		else if (st_r.cnt != '0)
			st_nxt.cnt = st_r.cnt - 24'h00_0001;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign out_o = bypass_i ? evt_i : (evt_i | (st_r.cnt != '0));
endmodule

// ### rtl/sil_top.sv
// Purpose: Three-output status indicator control with Wishbone registers
// Assumes: Status inputs synchronous to clk_i; classic Wishbone slave
// Notes:   Outputs registered; unmapped addresses read zero and still ack
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/100ps
module sil_top #(
	parameter int unsigned BLINK20 = sil_pkg::BLINK_CYC_20HZ,
	parameter int unsigned BLINK10 = sil_pkg::BLINK_CYC_10HZ,
	parameter int unsigned BLINK5  = sil_pkg::BLINK_CYC_5HZ,
	parameter int unsigned BLINK2  = sil_pkg::BLINK_CYC_2HZ,
	parameter int unsigned STRETCH = sil_pkg::STRETCH_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic        wb_we_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        link_good_i,
	input  wire logic        is_master_i,
	input  wire logic        tx_act_i,
	input  wire logic        rx_act_i,
	input  wire logic        mac_side_interface_err_i,
	input  wire logic        link_lost_i,
	input  wire logic        link_status_rd_i,
	input  wire logic        prbs_err_i,
	input  wire logic        prbs_clr_i,
	input  wire logic [1:0]  alt_sig_i,
	output logic      [2:0]  ind_o
);
	typedef struct packed {
		logic [15:0] cfg;
		logic [15:0] mux;
		logic [1:0]  lost;
		logic [2:0]  prbs;
		logic [31:0] dat;
		logic        ack;
		logic [2:0]  ind;
	} sil_st_t;

	sil_st_t st_r;
	sil_st_t st_nxt;
	logic    blink;
	logic    act_s;
	logic    err_s;
	logic    bypass;
	logic    req;
	logic [13:0] badr;

	// Per-output function decode; each output uses its own selector
	function automatic logic ind_fn(input logic [3:0] sel, input logic lg, input logic ms,
		input logic tx, input logic rx, input logic bl, input logic act, input logic err,
		input logic lost, input logic prbs);
		case (sel)
			sil_pkg::FN_LINK:    ind_fn = lg;
			sil_pkg::FN_LINK_ACT: ind_fn = lg & ~((tx | rx) & bl);
			sil_pkg::FN_LINK_TX: ind_fn = lg & ~(tx & bl);
			sil_pkg::FN_LINK_RX: ind_fn = lg & ~(rx & bl);
			sil_pkg::FN_MASTER:  ind_fn = lg & ms;
			sil_pkg::FN_SLAVE:   ind_fn = lg & ~ms;
			sil_pkg::FN_ACT:     ind_fn = act;
			sil_pkg::FN_LOST:    ind_fn = lost;
			sil_pkg::FN_PRBS:    ind_fn = prbs;
			sil_pkg::FN_MAC_ERR: ind_fn = err;
			default:             ind_fn = 1'b0;
		endcase
	endfunction

	// Pin mux for the two muxed outputs
	function automatic logic pin_mux(input logic [2:0] code, input logic fn, input logic alt);
		case (code)
			sil_pkg::MUX_INDICATOR: pin_mux = fn;
			sil_pkg::MUX_CONST0:    pin_mux = 1'b0;
			sil_pkg::MUX_CONST1:    pin_mux = 1'b1;
			default:                pin_mux = alt;
		endcase
	endfunction

	function automatic logic [15:0] wr_merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s, input logic [15:0] m);
		logic [15:0] v;
		v = old;
		if (s[0])
			v[7:0] = d[7:0];
		if (s[1])
			v[15:8] = d[15:8];
		wr_merge = v & m;
	endfunction

	assign bypass = st_r.cfg[sil_pkg::BYPASS_BIT];

	sil_blink #(
		.C20 (BLINK20),
		.C10 (BLINK10),
		.C5  (BLINK5),
		.C2  (BLINK2)
	) u_blink (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.rate_i  (st_r.cfg[sil_pkg::RATE_LSB +: 2]),
		.blink_o (blink)
	);

	sil_stretch #(
		.HOLD (STRETCH)
	) u_str_act (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.evt_i    (tx_act_i | rx_act_i),
		.bypass_i (bypass),
		.out_o    (act_s)
	);

	sil_stretch #(
		.HOLD (STRETCH)
	) u_str_err (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.evt_i    (mac_side_interface_err_i),
		.bypass_i (bypass),
		.out_o    (err_s)
	);

	assign req  = wb_cyc_i & wb_stb_i & ~st_r.ack;
	assign badr = wb_adr_i[13:0];

	always_comb
	begin
		logic [3:0] sels [3];
		logic [2:0] fn;
		logic       rd_stat;
		sels[0] = st_r.cfg[sil_pkg::SEL0_LSB +: 4];
		sels[1] = st_r.cfg[sil_pkg::SEL1_LSB +: 4];
		sels[2] = st_r.cfg[sil_pkg::SEL2_LSB +: 4];
		fn      = 3'b000;
		st_nxt  = st_r;
		rd_stat = 1'b0;
		st_nxt.ack = req;
		st_nxt.dat = '0;
		if (req)
		begin
			if (wb_adr_i[31:14] == '0 && badr == sil_pkg::ADR_IND_CFG)
			begin
				if (wb_we_i)
					st_nxt.cfg = wr_merge(st_r.cfg, wb_dat_i, wb_sel_i, sil_pkg::IND_CFG_WMASK);
				else
					st_nxt.dat = {16'h0000, st_r.cfg};
			end
			else if (wb_adr_i[31:14] == '0 && badr == sil_pkg::ADR_MUX_CFG)
			begin
				if (wb_we_i)
					st_nxt.mux = wr_merge(st_r.mux, wb_dat_i, wb_sel_i, sil_pkg::MUX_CFG_WMASK);
				else
					st_nxt.dat = {16'h0000, st_r.mux};
			end
			else if (wb_adr_i[31:14] == '0 && badr == sil_pkg::ADR_IND_STAT && !wb_we_i)
			begin
				st_nxt.dat = {29'h0000_0000, st_r.prbs[0], st_r.lost[0], link_good_i};
				rd_stat = 1'b1;
			end
		end
		st_nxt.lost[0] = link_lost_i | (st_r.lost[0] & ~(link_status_rd_i | rd_stat));
		st_nxt.prbs[0] = prbs_err_i | (st_r.prbs[0] & ~prbs_clr_i);
		st_nxt.lost[1] = 1'b0;
		st_nxt.prbs[2:1] = 2'b00;
		// each output from its own selector
		for (int i = 0; i < 3; i++)
			fn[i] = ind_fn(sels[i], link_good_i, is_master_i, tx_act_i, rx_act_i, blink,
				act_s, err_s, st_r.lost[0], st_r.prbs[0]);
		// mux only on outputs 0 and 1
		st_nxt.ind[0] = pin_mux(st_r.mux[2:0], fn[0], alt_sig_i[0]);
		st_nxt.ind[1] = pin_mux(st_r.mux[sil_pkg::MUX1_LSB +: 3], fn[1], alt_sig_i[1]);
		st_nxt.ind[2] = fn[2];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_r     <= '0;
			st_r.cfg <= sil_pkg::IND_CFG_RST;
			st_r.mux <= sil_pkg::MUX_CFG_RST;
		end
		else
			st_r <= st_nxt;
	end

	assign wb_dat_o = st_r.dat;
	assign wb_ack_o = st_r.ack;
	assign ind_o    = st_r.ind;
endmodule

// ### verification/sil_lamp.sv
// Purpose: Indicator lamp on the board side
// Assumes: Lamp lit while its output is high
// Notes:   Counts turn-on events so a blink rate can be judged
`timescale 1ns/100ps
module sil_lamp (
	input  wire logic clk_i,
	input  wire logic on_i,
	output int        rises_o
);
	bit lit_r;
	always_ff @(posedge clk_i)
	begin
		rises_o <= rises_o + int'(on_i && !lit_r);
		lit_r   <= on_i;
	end
endmodule

// ### verification/sil_props.sv
// Purpose: Port-level checks of the status indicator block
// Assumes: STRETCH of at least 9 cycles; registers shadowed from bus writes
// Notes:   Shadows update at the edge a write is taken, as the block does
`timescale 1ns/100ps
module sil_props (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic        wb_we_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        link_good_i,
	input wire logic        is_master_i,
	input wire logic        tx_act_i,
	input wire logic        rx_act_i,
	input wire logic        link_lost_i,
	input wire logic        link_status_rd_i,
	input wire logic        prbs_err_i,
	input wire logic [2:0]  ind_o
);
	logic [15:0] cfg_r;
	logic [15:0] mux_r;
	logic [15:0] lane;
	logic        take_wr;
	logic [3:0]  sel2;
	assign lane    = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign take_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i[31:14] == 18'h0_0000;
	assign sel2    = cfg_r[11:8];
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cfg_r <= sil_pkg::IND_CFG_RST;
			mux_r <= sil_pkg::MUX_CFG_RST;
		end
		else if (take_wr && wb_adr_i[13:0] == sil_pkg::ADR_IND_CFG)
			cfg_r <= cfg_r & ~(lane & sil_pkg::IND_CFG_WMASK) | wb_dat_i[15:0] & lane & sil_pkg::IND_CFG_WMASK;
		else if (take_wr && wb_adr_i[13:0] == sil_pkg::ADR_MUX_CFG)
			mux_r <= mux_r & ~(lane & sil_pkg::MUX_CFG_WMASK) | wb_dat_i[15:0] & lane & sil_pkg::MUX_CFG_WMASK;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence act_seen;
		sel2 == sil_pkg::FN_ACT && !cfg_r[14] && (tx_act_i || rx_act_i);
	endsequence
	// Latched functions show one cycle later than plain ones: the latch itself is a flop
	sequence lost_evt;
		sel2 == sil_pkg::FN_LOST && link_lost_i ##1 sel2 == sil_pkg::FN_LOST;
	endsequence
	sequence prbs_evt;
		sel2 == sil_pkg::FN_PRBS && prbs_err_i ##1 sel2 == sil_pkg::FN_PRBS;
	endsequence
	ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acknowledged next cycle");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside ack");
	ind_reset_a: assert property ($fell(rst_i) |-> ind_o == 3'h0)
		else $error("indicators not off after reset");
	link_steady_a: assert property (cfg_r[3:0] == sil_pkg::FN_LINK && mux_r[2:0] == sil_pkg::MUX_INDICATOR
		|=> ind_o[0] == $past(link_good_i)) else $error("steady link lamp wrong");
	role_show_a: assert property (sel2 == sil_pkg::FN_MASTER || sel2 == sil_pkg::FN_SLAVE
		|=> ind_o[2] == $past(link_good_i && (is_master_i != sel2[0]))) else $error("role lamp wrong");
	rsvd_off_a: assert property (sel2 == 4'h7 || sel2 == 4'h8 || sel2 >= 4'hC |=> !ind_o[2])
		else $error("reserved code lit lamp");
	pin_const_a: assert property (mux_r[2:1] == 2'b11 |=> ind_o[0] == $past(mux_r[0]))
		else $error("constant pin level wrong");
	bypass_act_a: assert property (sel2 == sil_pkg::FN_ACT && cfg_r[14]
		|=> ind_o[2] == $past(tx_act_i || rx_act_i)) else $error("bypassed activity wrong");
	stretch_hold_a: assert property (act_seen |=> (ind_o[2] || sel2 != sil_pkg::FN_ACT || cfg_r[14])[*8])
		else $error("activity pulse not stretched");
	lost_set_a: assert property (lost_evt |=> ind_o[2])
		else $error("link lost not shown");
	lost_hold_a: assert property (sel2 == sil_pkg::FN_LOST && $stable(cfg_r) && !$past(link_status_rd_i)
		&& ind_o[2] && !$past(wb_cyc_i) |=> ind_o[2]) else $error("link lost dropped early");
	prbs_set_a: assert property (prbs_evt |=> ind_o[2])
		else $error("pattern error not shown");
endmodule
bind sil_top sil_props u_props (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
	.wb_dat_o, .wb_ack_o, .link_good_i, .is_master_i, .tx_act_i, .rx_act_i, .link_lost_i, .link_status_rd_i,
	.prbs_err_i, .ind_o);

// ### verification/status_indicator_led_control_tb_top.sv
// Purpose: Self-checking bench of the status indicator block
// Assumes: Shortened blink and stretch counts
// Notes:   Every wait is bounded; a lost ack ends the run
`timescale 1ns/100ps
module status_indicator_led_control_tb_top;
	localparam logic [31:0] A_CFG = {18'h0_0000, sil_pkg::ADR_IND_CFG};
	localparam logic [31:0] A_MUX = {18'h0_0000, sil_pkg::ADR_MUX_CFG};
	localparam logic [31:0] A_ST  = {18'h0_0000, sil_pkg::ADR_IND_STAT};
	logic        clk_i       = 1'b0;
	logic        rst_i       = 1'b1;
	logic [31:0] wb_adr_i    = 32'h0000_0000;
	logic [31:0] wb_dat_i    = 32'h0000_0000;
	logic [3:0]  wb_sel_i    = 4'hF;
	logic        wb_we_i     = 1'b0;
	logic        wb_cyc_i    = 1'b0;
	logic        wb_stb_i    = 1'b0;
	logic        link_good_i = 1'b0;
	logic        is_master_i = 1'b0;
	logic [6:0]  ev          = 7'h00;
	logic [1:0]  alt         = 2'b00;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [2:0]  ind_o;
	logic [31:0] q;
	int          rises;
	int          fail_count  = 0;
	int          n_compared  = 0;
	always #12.5 clk_i = ~clk_i;
	sil_top #(.BLINK20(8), .BLINK10(16), .BLINK5(32), .BLINK2(64), .STRETCH(10)) uut (
		.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
		.link_good_i, .is_master_i, .tx_act_i(ev[0]), .rx_act_i(ev[6]), .mac_side_interface_err_i(ev[1]),
		.link_lost_i(ev[2]), .link_status_rd_i(ev[3]), .prbs_err_i(ev[4]), .prbs_clr_i(ev[5]),
		.alt_sig_i(alt), .ind_o);
	sil_lamp lamp (.clk_i, .on_i(ind_o[1]), .rises_o(rises));
	task automatic finish_test;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		for (n = 0; n < 16 && wb_ack_o !== 1'b1; n++)
			@(posedge clk_i);
		if (n == 16)
		begin
			chk(wb_ack_o, 1'b1);
			finish_test;
		end
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0000_0000);
		chk(q, exp);
	endtask
	task automatic cfg(input logic b, input logic [1:0] r, input logic [3:0] s2, input logic [3:0] s1,
		input logic [3:0] s0);
		wb(1'b1, A_CFG, {17'h0_0000, b, r, s2, s1, s0});
		tick(3);
	endtask
	task automatic pulse(input int b);
		@(posedge clk_i);
		ev[b] <= 1'b1;
		@(posedge clk_i);
		ev[b] <= 1'b0;
	endtask
	task automatic t_regs;
		rd(A_CFG, 32'h0000_2610);
		rd(A_MUX, 32'h0000_0000);
		wb(1'b1, A_CFG, 32'hFFFF_FFFF);
		rd(A_CFG, 32'h0000_7FFF);
		rd(32'h0000_0004, 32'h0000_0000);
	endtask
	task automatic t_link;
		cfg(1'b0, 2'h2, 4'h6, 4'h1, 4'h0);
		tick(3);
		chk(ind_o[1:0], 2'b00);
		link_good_i <= 1'b1;
		tick(3);
		chk(ind_o[1:0], 2'b11);
	endtask
	task automatic t_role;
		for (int m = 0; m < 2; m++)
		begin
			is_master_i <= m[0];
			cfg(1'b0, 2'h2, sil_pkg::FN_MASTER, 4'h1, 4'h0);
			chk(ind_o[2], m[0]);
			cfg(1'b0, 2'h2, sil_pkg::FN_SLAVE, 4'h1, 4'h0);
			chk(ind_o[2], !m[0]);
		end
	endtask
	task automatic t_rsvd;
		logic [3:0] codes [6] = '{4'h7, 4'h8, 4'hC, 4'hD, 4'hE, 4'hF};
		ev[0] <= 1'b1;
		ev[6] <= 1'b1;
		foreach (codes[i])
		begin
			cfg(1'b0, 2'h2, codes[i], 4'h1, 4'h0);
			chk(ind_o[2], 1'b0);
		end
		ev <= 7'h00;
	endtask
	task automatic t_stretch;
		for (int k = 0; k < 2; k++)
		begin
			cfg(1'b0, 2'h2, k ? sil_pkg::FN_MAC_ERR : sil_pkg::FN_ACT, 4'h1, 4'h0);
			pulse(k);
			tick(4);
			chk(ind_o[2], 1'b1);
			tick(12);
			chk(ind_o[2], 1'b0);
			cfg(1'b1, 2'h2, k ? sil_pkg::FN_MAC_ERR : sil_pkg::FN_ACT, 4'h1, 4'h0);
			ev[k] <= 1'b1;
			tick(3);
			chk(ind_o[2], 1'b1);
			ev[k] <= 1'b0;
			tick(3);
			chk(ind_o[2], 1'b0);
		end
	endtask
	task automatic t_latch;
		for (int k = 0; k < 2; k++)
		begin
			cfg(1'b0, 2'h2, k ? sil_pkg::FN_LOST : sil_pkg::FN_PRBS, 4'h1, 4'h0);
			pulse(4 - 2 * k);
			tick(20);
			chk(ind_o[2], 1'b1);
			pulse(5 - 2 * k);
			tick(3);
			chk(ind_o[2], 1'b0);
		end
		pulse(2);
		rd(A_ST, 32'h0000_0003);
		tick(3);
		chk(ind_o[2], 1'b0);
	endtask
	task automatic t_mux;
		link_good_i <= 1'b0;
		wb(1'b1, A_MUX, 32'h0000_0007);
		tick(3);
		chk(ind_o[0], 1'b1);
		link_good_i <= 1'b1;
		wb(1'b1, A_MUX, 32'h0000_0006);
		tick(3);
		chk(ind_o[0], 1'b0);
		wb(1'b1, A_MUX, 32'h0000_0303);
		alt <= 2'b01;
		tick(3);
		chk(ind_o[1:0], 2'b01);
		alt <= 2'b10;
		tick(3);
		chk(ind_o[1:0], 2'b10);
		alt <= 2'b00;
		wb(1'b1, A_MUX, 32'h0000_0000);
		tick(3);
		chk(ind_o[0], 1'b1);
	endtask
	task automatic t_blink;
		int c;
		ev[0] <= 1'b1;
		for (int r = 0; r < 4; r++)
		begin
			cfg(1'b0, r[1:0], 4'h6, 4'h1, 4'h0);
			tick(130);
			c = rises;
			tick(512);
			c = rises - c;
			chk(c >= (32 >> r) - 1 && c <= (32 >> r) + 1, 1'b1);
		end
		ev[0] <= 1'b0;
	endtask
	initial
	begin
		tick(20);
		rst_i <= 1'b0;
		t_regs;
		t_link;
		t_role;
		t_rsvd;
		t_stretch;
		t_latch;
		t_mux;
		t_blink;
		finish_test;
	end
endmodule
